// ### bench/csc_lan_src.sv
// LAN interrupt source model with driver acknowledge
`timescale 1ns/1ps
`default_nettype none
module csc_lan_src
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic raise,
  input wire logic ack,
  output logic pend
);
  always_ff @(posedge clk)
  begin
    if (!rst_n || ack) pend <= 1'b0;
    else if (raise) pend <= 1'b1;
  end
endmodule
`default_nettype wire

// ### bench/csc_sva_asserts.sv
// Port assertions for the status change block
`timescale 1ns/1ps
`default_nettype none
module csc_sva
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic LAN_INT_PENDING,
  input wire logic WAKE_LINK_CHANGE,
  input wire logic WAKE_REMOTE_FRAME,
  input wire logic WAKE_FILTERED_FRAME,
  input wire logic LINK_WAKE_EN,
  input wire logic REMOTE_WAKE_DIS,
  input wire logic FILTER_WAKE_EN,
  input wire logic PME_EN,
  input wire logic WAKE_EVENT_CLR,
  input wire logic WAKE_EVENT,
  input wire logic CSTSCHG
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire logic w = (WAKE_LINK_CHANGE & LINK_WAKE_EN) | (WAKE_REMOTE_FRAME & ~REMOTE_WAKE_DIS)
    | (WAKE_FILTERED_FRAME & FILTER_WAKE_EN);
  a_ev_set: assert property (w |=> WAKE_EVENT) else $error("no event");
  a_ev_clr: assert property (WAKE_EVENT_CLR && !w |=> !WAKE_EVENT)
    else $error("event kept");
  a_cst_pme: assert property (w && PME_EN |=> CSTSCHG) else $error("pme");
  a_cst_src: assert property (CSTSCHG |-> WAKE_EVENT) else $error("cst");
  a_int_live: assert property (REG_RVALID && $past(REG_ADDR) == 8'h38
    |-> REG_RDATA[15] == $past(LAN_INT_PENDING, 2)) else $error("int");
  a_wake_or: assert property (REG_RVALID && $past(REG_ADDR) == 8'h38
    |-> REG_RDATA[4] == $past(w, 2)) else $error("wake");
  a_ps_rsv: assert property (REG_RVALID && $past(REG_ADDR) == 8'h38
    |-> (REG_RDATA & 32'hFFFF7FE9) == 32'h0) else $error("ps rsv");
  a_mask_rsv: assert property (REG_RVALID && $past(REG_ADDR) == 8'h34
    |-> (REG_RDATA & 32'hFFFF3FE9) == 32'h0) else $error("mask rsv");
endmodule
bind csc_status_change csc_sva sva_u
(
  .CLK(CLK),
  .RST_N(RST_N),
  .REG_ADDR(REG_ADDR),
  .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID),
  .LAN_INT_PENDING(LAN_INT_PENDING),
  .WAKE_LINK_CHANGE(WAKE_LINK_CHANGE),
  .WAKE_REMOTE_FRAME(WAKE_REMOTE_FRAME),
  .WAKE_FILTERED_FRAME(WAKE_FILTERED_FRAME),
  .LINK_WAKE_EN(LINK_WAKE_EN),
  .REMOTE_WAKE_DIS(REMOTE_WAKE_DIS),
  .FILTER_WAKE_EN(FILTER_WAKE_EN),
  .PME_EN(PME_EN),
  .WAKE_EVENT_CLR(WAKE_EVENT_CLR),
  .WAKE_EVENT(WAKE_EVENT),
  .CSTSCHG(CSTSCHG)
);
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the status change block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import csc_pkg::*;
  logic CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, PME_EN = 0, clr = 0, raise = 0, ack = 0;
  logic [2:0] src = 0, gt = 0;
  logic [1:0] bat = 0;
  logic [7:0] REG_ADDR = 0;
  logic [31:0] REG_WDATA = 0, REG_RDATA, r = 97419;
  logic REG_RVALID, WAKE_EVENT, CSTSCHG, pend;
  logic [31:0] q[$];
  int mismatches = 0, samples_checked = 0;
  always #25 CLK = ~CLK;
  csc_lan_src lan_u(.clk(CLK), .rst_n(RST_N), .raise(raise), .ack(ack), .pend(pend));
  csc_status_change dut_u(.CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .LAN_INT_PENDING(pend), .WAKE_LINK_CHANGE(src[2]),
    .WAKE_REMOTE_FRAME(src[1]), .WAKE_FILTERED_FRAME(src[0]), .LINK_WAKE_EN(gt[2]),
    .REMOTE_WAKE_DIS(gt[1]), .FILTER_WAKE_EN(gt[0]), .PME_EN(PME_EN), .BATT_RDY_IN(bat[1]),
    .BATT_WP_IN(bat[0]), .WAKE_EVENT_CLR(clr), .WAKE_EVENT(WAKE_EVENT), .CSTSCHG(CSTSCHG));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    REG_WR <= 1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge CLK);
    REG_RD <= 1;
    REG_ADDR <= a;
    q.push_back(x);
    @(posedge CLK);
    REG_RD <= 0;
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Read results in request order, sampled away from the launching edge
  always @(negedge CLK)
  begin
    if (REG_RVALID === 1'b1)
    begin
      if (q.size() == 0)
      begin
        mismatches++;
        $display("[ERR] %0t got %h exp %h", $time, REG_RDATA, 32'h0);
      end
      else
        chk(REG_RDATA, q.pop_front());
    end
  end
  // Card mode accesses only
  initial
  begin
    repeat (5) @(posedge CLK);
    RST_N <= 1;
    rd(8'h34, 32'h0);
    rd(8'h38, 32'h0);
    r = lfsr(r);
    wr(8'h34, r);
    rd(8'h34, r & 32'h0000C016);
    wr(8'h38, 32'hFFFFFFFF);
    rd(8'h38, 32'h0);
    rd(8'h34, r & 32'h0000C016);
    rd(8'h3C, 32'h0);
    $display("regs done");
    for (int i = 0; i < 64; i++)
    begin
      r = lfsr(r);
      {src, gt} <= i[5:0];
      bat <= r[1:0];
      rd(8'h38, {27'h0, (i[5] & i[2]) | (i[4] & ~i[1]) | (i[3] & i[0]), 1'b0, r[1:0], 1'b0});
    end
    $display("wake done");
    src <= 0;
    bat <= 0;
    raise <= 1;
    @(posedge CLK);
    raise <= 0;
    rd(8'h38, 32'h8000);
    rd(8'h38, 32'h8000);
    ack <= 1;
    @(posedge CLK);
    ack <= 0;
    rd(8'h38, 32'h0);
    $display("int done");
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h34, {17'h0, k[1], 9'h0, k[0], 4'h0});
      PME_EN <= k[2];
      clr <= 1;
      @(posedge CLK);
      clr <= 0;
      {src, gt} <= 6'h24;
      @(posedge CLK);
      src <= 0;
      #1;
      chk(WAKE_EVENT, 1);
      chk(CSTSCHG, k[2] | (k[1] & k[0]));
    end
    clr <= 1;
    @(posedge CLK);
    clr <= 0;
    #1;
    chk(WAKE_EVENT, 0);
    $display("output done");
    repeat (4) @(posedge CLK);
    if (q.size() != 0)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, q.size(), 0);
    end
    final_report();
  end
endmodule
`default_nettype wire

// ### design/csc_params.svh
// Offsets, field positions, masks and reset values of the status change registers
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

`define CSC_ADDR_W 8
`define CSC_OFS_MASK 8'h34
`define CSC_OFS_PRESENT 8'h38

`define CSC_BIT_LAN_INT 15
`define CSC_BIT_WAKE_OUT 14
`define CSC_BIT_GEN_WAKE 4
`define CSC_BIT_BATT_RDY 2
`define CSC_BIT_BATT_WP 1

`define CSC_MASK_WRITABLE 32'h0000C016
`define CSC_MASK_RESET 32'h00000000
`define CSC_PRESENT_RESET 32'h00000000
`define CSC_RDATA_RESET 32'h00000000

`endif

// ### design/csc_pkg.sv
// Types shared by the status change event logic
package csc_pkg;

  typedef enum logic [1:0] {
    CSC_SEL_NONE,
    CSC_SEL_MASK,
    CSC_SEL_PRESENT
  } csc_sel_e;

  // Wake sources from the power management driver register
  typedef struct packed {
    logic link_change;
    logic remote_frame;
    logic filtered_frame;
  } csc_wake_src_s;

  // Gates loaded by the configuration and filter commands
  typedef struct packed {
    logic link_wake_en;
    logic remote_wake_dis;
    logic filter_en;
  } csc_wake_gate_s;

  // Host access to the CSR window
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } csc_req_s;

  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] rdata;
    logic rvalid;
    logic lan_int;
    logic gen_wake;
    logic batt_rdy;
    logic batt_wp;
    logic wake_event;
    logic cstschg;
  } csc_state_s;

endpackage

// ### design/csc_status_change.sv
// Card status change mask, present state and status change output
`timescale 1ns/1ps
`default_nettype none
`include "csc_params.svh"

module csc_status_change
  import csc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic LAN_INT_PENDING,
  input wire logic WAKE_LINK_CHANGE,
  input wire logic WAKE_REMOTE_FRAME,
  input wire logic WAKE_FILTERED_FRAME,
  input wire logic LINK_WAKE_EN,
  input wire logic REMOTE_WAKE_DIS,
  input wire logic FILTER_WAKE_EN,
  input wire logic PME_EN,
  input wire logic BATT_RDY_IN,
  input wire logic BATT_WP_IN,
  input wire logic WAKE_EVENT_CLR,
  output logic WAKE_EVENT,
  output logic CSTSCHG
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of the host address
  function automatic csc_sel_e decode(input logic [7:0] addr);
    csc_sel_e sel;
    sel = CSC_SEL_NONE;
    if (addr == `CSC_OFS_MASK)
    begin
      sel = CSC_SEL_MASK;
    end
    else if (addr == `CSC_OFS_PRESENT)
    begin
      sel = CSC_SEL_PRESENT;
    end
    return sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Present state word from current state
  function automatic logic [31:0] present_word(input csc_state_s s);
    logic [31:0] w;
    w = `CSC_PRESENT_RESET;
    w[`CSC_BIT_LAN_INT] = s.lan_int;
    w[`CSC_BIT_GEN_WAKE] = s.gen_wake;
    w[`CSC_BIT_BATT_RDY] = s.batt_rdy;
    w[`CSC_BIT_BATT_WP] = s.batt_wp;
    return w;
  endfunction

  csc_state_s state_q;
  csc_state_s state_d;
  csc_req_s req;
  csc_wake_src_s src;
  csc_wake_gate_s gate;
  csc_sel_e sel;
  logic wake_now;
  logic out_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Bundling of the inputs
  always_comb
  begin
    req.wr = REG_WR;
    req.rd = REG_RD;
    req.addr = REG_ADDR;
    req.wdata = REG_WDATA;
    src.link_change = WAKE_LINK_CHANGE;
    src.remote_frame = WAKE_REMOTE_FRAME;
    src.filtered_frame = WAKE_FILTERED_FRAME;
    gate.link_wake_en = LINK_WAKE_EN;
    gate.remote_wake_dis = REMOTE_WAKE_DIS;
    gate.filter_en = FILTER_WAKE_EN;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gated wake sources
  csc_wake_gate u_wake_gate
  (
    .src(src),
    .gate(gate),
    .wake(wake_now)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    state_d = state_q;
    sel = decode(req.addr);
    state_d.rvalid = 1'b0;

    // Mask register write, only defined bits stored
    if (req.wr && (sel == CSC_SEL_MASK))
    begin
      state_d.mask = req.wdata & `CSC_MASK_WRITABLE;
    end
    // Writes to the present state address fall through untouched

    // Present state mirrors its sources
    state_d.lan_int = LAN_INT_PENDING;
    state_d.gen_wake = wake_now;
    state_d.batt_rdy = BATT_RDY_IN;
    state_d.batt_wp = BATT_WP_IN;

    // Sticky general wake event, set beats clear
    if (wake_now)
    begin
      state_d.wake_event = 1'b1;
    end
    else if (WAKE_EVENT_CLR)
    begin
      state_d.wake_event = 1'b0;
    end

    // Status change output
    out_enable = (state_d.mask[`CSC_BIT_WAKE_OUT] & state_d.mask[`CSC_BIT_GEN_WAKE])
      | PME_EN;
    state_d.cstschg = state_d.wake_event & out_enable;

    // Read data
    if (req.rd)
    begin
      state_d.rvalid = 1'b1;
      unique case (sel)
        CSC_SEL_MASK:
        begin
          state_d.rdata = state_q.mask;
        end
        CSC_SEL_PRESENT:
        begin
          state_d.rdata = present_word(state_q);
        end
        CSC_SEL_NONE:
        begin
          state_d.rdata = `CSC_RDATA_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_q.mask <= `CSC_MASK_RESET;
      state_q.rdata <= `CSC_RDATA_RESET;
      state_q.rvalid <= 1'b0;
      state_q.lan_int <= 1'b0;
      state_q.gen_wake <= 1'b0;
      state_q.batt_rdy <= 1'b0;
      state_q.batt_wp <= 1'b0;
      state_q.wake_event <= 1'b0;
      state_q.cstschg <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign REG_RDATA = state_q.rdata;
  assign REG_RVALID = state_q.rvalid;
  assign WAKE_EVENT = state_q.wake_event;
  assign CSTSCHG = state_q.cstschg;

endmodule

`default_nettype wire

// ### design/csc_wake_gate.sv
// Gated OR of the three wake sources
`timescale 1ns/1ps
`default_nettype none

module csc_wake_gate
  import csc_pkg::*;
(
  input wire csc_wake_src_s src,
  input wire csc_wake_gate_s gate,
  output logic wake
);

  logic link_part;
  logic remote_part;
  logic filter_part;

  ////////////////////////////////////////////////////////////////////////////
  // Each source passes only under its own gate
  always_comb
  begin
    link_part = src.link_change & gate.link_wake_en;
    remote_part = src.remote_frame & ~gate.remote_wake_dis;
    filter_part = src.filtered_frame & gate.filter_en;
    wake = link_part | remote_part | filter_part;
  end

endmodule

`default_nettype wire
